// ===== avionics_chan_pkg.sv
// Constants shared by the avionics serial channel register bank.
// Assumes a single 40 MHz system clock and one channel per instance.
package avionics_chan_pkg;

    // Register select codes on the host write port.
    localparam logic [1:0] SEL_RX_CTRL = 2'h0;
    localparam logic [1:0] SEL_LABEL   = 2'h1;
    localparam logic [1:0] SEL_TX_DATA = 2'h2;
    localparam logic [1:0] SEL_TX_CTRL = 2'h3;

    // Receive control bit positions.
    localparam int RXC_RATE     = 0;
    localparam int RXC_LABEL_EN = 1;
    localparam int RXC_CLR_PE   = 2;
    localparam int RXC_PARITY   = 3;
    localparam int RXC_SDI_EN   = 4;
    localparam int RXC_SDI_LO   = 5;
    localparam int RXC_SDI_HI   = 6;
    localparam int RXC_RELOAD   = 7;

    // Transmit control bit positions.
    localparam int TXC_RATE   = 0;
    localparam int TXC_LOOP   = 1;
    localparam int TXC_RSVD   = 2;
    localparam int TXC_PARITY = 3;

    // Status bit positions; empty, level and full are shared by receive and transmit status, parity is receive only.
    localparam int ST_EMPTY  = 0;
    localparam int ST_LEVEL  = 1;
    localparam int ST_FULL   = 2;
    localparam int ST_PARITY = 3;
    localparam int ST_TX_LSB = 4;

    // Positions inside a received word.
    localparam int WORD_SDI_LO = 8;
    localparam int WORD_SDI_HI = 9;
    localparam int LABEL_W     = 8;

    // Values after reset.
    localparam logic [7:0] RX_CTRL_RST = 8'h00;
    localparam logic [3:0] TX_CTRL_RST = 4'h0;
    localparam logic [7:0] STATUS_RST  = 8'h11;

    // Build-time defaults.
    localparam logic [2:0] CLK_CODE_DEFAULT   = 3'h0;
    localparam logic [3:0] CHANNEL_DEFAULT    = 4'h8;
    localparam int         FIFO_DEPTH_DEFAULT = 32;
    localparam int         FIFO_LEVEL_DEFAULT = 16;
    localparam int         FIFO_PTR_W_DEFAULT = 5;
    localparam int         LABEL_SIZE_DEFAULT = 64;
    localparam int         STAGE_DEPTH        = 4;
    localparam int         STAGE_PTR_W        = 2;

    // Input clock frequency in MHz for each selection code.
    function automatic logic [7:0] clock_mhz(input logic [2:0] code);
        case (code)
            3'h0:    clock_mhz = 8'h30;
            3'h1:    clock_mhz = 8'h04;
            3'h2:    clock_mhz = 8'h0c;
            3'h3:    clock_mhz = 8'h10;
            3'h4:    clock_mhz = 8'h14;
            3'h5:    clock_mhz = 8'h18;
            3'h6:    clock_mhz = 8'h34;
            default: clock_mhz = 8'h30;
        endcase
    endfunction : clock_mhz

endpackage : avionics_chan_pkg

// ===== serial_avionics_channel_regs.sv
// Register bank, label filter and word FIFOs of one avionics serial channel.
// Assumes a serial engine that delivers and takes whole 32-bit words by valid/ready.
`timescale 1ns/1ps

module stream_fifo
    import avionics_chan_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = STAGE_DEPTH,
    parameter int PTR_W = STAGE_PTR_W
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    // Fill level
    output logic      [PTR_W:0]   fill_count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic             push;
    logic             pop;
    logic [PTR_W:0]   next_count;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = fill_count;
        if (push && !pop) begin
            next_count = fill_count + (PTR_W+1)'(1);
        end else if (pop && !push) begin
            next_count = fill_count - (PTR_W+1)'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PTR_W'(1);
            end
        end
    end

    // Flags are registered so that ready and valid come straight from flops.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_count <= '0;
            in_ready   <= 1'b1;
            out_valid  <= 1'b0;
        end else begin
            fill_count <= next_count;
            in_ready   <= next_count != (PTR_W+1)'(DEPTH);
            out_valid  <= next_count != '0;
        end
    end

endmodule : stream_fifo

module serial_avionics_channel_regs
    import avionics_chan_pkg::*;
#(
    parameter logic [2:0] INPUT_CLOCK_CODE = CLK_CODE_DEFAULT,
    parameter logic [3:0] CHANNEL          = CHANNEL_DEFAULT,
    parameter int         FIFO_DEPTH       = FIFO_DEPTH_DEFAULT,
    parameter int         FIFO_LEVEL       = FIFO_LEVEL_DEFAULT,
    parameter int         FIFO_PTR_W       = FIFO_PTR_W_DEFAULT,
    parameter int         LABEL_SIZE       = LABEL_SIZE_DEFAULT
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Host write port
    input  wire logic        register_write_strobe,
    input  wire logic [1:0]  target_register_code,
    input  wire logic [3:0]  write_channel,
    input  wire logic [31:0] write_data,
    // Host receive FIFO read port
    input  wire logic        read_request,
    input  wire logic [3:0]  read_channel,
    output logic      [31:0] read_data,
    // Status byte
    output logic      [7:0]  status_byte,
    // Words from the serial receiver
    input  wire logic [31:0] rx_word,
    input  wire logic        rx_word_valid,
    output logic             rx_word_ready,
    // Words to the serial transmitter
    output logic      [31:0] tx_word,
    output logic             tx_word_valid,
    input  wire logic        tx_word_ready,
    // Settings for the serial engine
    output logic      [7:0]  sample_clock_mhz,
    output logic             rx_slow_rate,
    output logic             rx_parity_even,
    output logic             tx_slow_rate,
    output logic             tx_parity_even,
    output logic             loopback_en
);
    localparam int LPTR_W = $clog2(LABEL_SIZE + 1);

    logic [7:0]            rx_ctrl;
    logic [3:0]            tx_ctrl;
    logic                  parity_fault_flag;
    logic [LABEL_W-1:0]    label_mem [LABEL_SIZE];
    logic [LPTR_W-1:0]     label_wr_ptr;
    logic                  wr_here;
    logic                  clear_pe;
    logic [31:0]           stage_data;
    logic                  stage_valid;
    logic                  take;
    logic                  label_hit;
    logic                  sdi_ok;
    logic                  parity_bad;
    logic                  accept;
    logic                  rx_in_ready;
    logic [31:0]           rx_out_data;
    logic                  rx_out_valid;
    logic                  rx_pop;
    logic [FIFO_PTR_W:0]   rx_count;
    logic                  tx_in_ready;
    logic [31:0]           tx_out_data;
    logic                  tx_out_valid;
    logic                  tx_pop;
    logic [FIFO_PTR_W:0]   tx_count;

    // The strobe is one clock long, so each write acts exactly once.
    assign wr_here  = register_write_strobe && write_channel == CHANNEL;
    assign clear_pe = wr_here && target_register_code == SEL_RX_CTRL && write_data[RXC_CLR_PE];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_ctrl <= RX_CTRL_RST;
        end else if (wr_here && target_register_code == SEL_RX_CTRL) begin
            // The clear bit acts as a command and is not stored.
            rx_ctrl <= write_data[7:0] & ~(8'h01 << RXC_CLR_PE);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_ctrl <= TX_CTRL_RST;
        end else if (wr_here && target_register_code == SEL_TX_CTRL) begin
            tx_ctrl <= write_data[3:0] & ~(4'h1 << TXC_RSVD);
        end
    end

    // Old labels stay in memory but are ignored once the pointer is zeroed.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            label_wr_ptr <= '0;
        end else if (rx_ctrl[RXC_RELOAD]) begin
            label_wr_ptr <= '0;
        end else if (wr_here && target_register_code == SEL_LABEL && label_wr_ptr != LPTR_W'(LABEL_SIZE)) begin
            label_wr_ptr <= label_wr_ptr + LPTR_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (wr_here && target_register_code == SEL_LABEL && !rx_ctrl[RXC_RELOAD]
            && label_wr_ptr != LPTR_W'(LABEL_SIZE)) begin
            label_mem[label_wr_ptr[LPTR_W-2:0]] <= write_data[LABEL_W-1:0];
        end
    end

    // Staging buffer between the serial receiver and the checks.
    stream_fifo #(
        .WIDTH (32),
        .DEPTH (STAGE_DEPTH),
        .PTR_W (STAGE_PTR_W)
    ) stage_fifo (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .in_data    (rx_word),
        .in_valid   (rx_word_valid),
        .in_ready   (rx_word_ready),
        .out_data   (stage_data),
        .out_valid  (stage_valid),
        .out_ready  (rx_in_ready),
        .fill_count ()
    );

    always_comb begin
        label_hit = 1'b0;
        for (int i = 0; i < LABEL_SIZE; i++) begin
            if (LPTR_W'(i) < label_wr_ptr && label_mem[i] == stage_data[LABEL_W-1:0]) begin
                label_hit = 1'b1;
            end
        end
    end

    assign take       = stage_valid && rx_in_ready;
    assign sdi_ok     = !rx_ctrl[RXC_SDI_EN]
                        || (stage_data[WORD_SDI_LO] == rx_ctrl[RXC_SDI_LO]
                            && stage_data[WORD_SDI_HI] == rx_ctrl[RXC_SDI_HI]);
    assign parity_bad = (^stage_data) == rx_ctrl[RXC_PARITY];
    assign accept     = take && (!rx_ctrl[RXC_LABEL_EN] || label_hit) && sdi_ok;

    // A parity fault arriving with a clear command wins over the clear.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            parity_fault_flag <= 1'b0;
        end else if (take && parity_bad) begin
            parity_fault_flag <= 1'b1;
        end else if (clear_pe) begin
            parity_fault_flag <= 1'b0;
        end
    end

    stream_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH),
        .PTR_W (FIFO_PTR_W)
    ) rx_fifo (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .in_data    (stage_data),
        .in_valid   (accept),
        .in_ready   (rx_in_ready),
        .out_data   (rx_out_data),
        .out_valid  (rx_out_valid),
        .out_ready  (rx_pop),
        .fill_count (rx_count)
    );

    assign rx_pop = read_request && read_channel == CHANNEL;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            read_data <= '0;
        end else if (rx_pop) begin
            read_data <= rx_out_valid ? rx_out_data : 32'h0;
        end
    end

    // Transmit data writes are dropped by the FIFO while it is full.
    stream_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH),
        .PTR_W (FIFO_PTR_W)
    ) tx_fifo (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .in_data    (write_data),
        .in_valid   (wr_here && target_register_code == SEL_TX_DATA),
        .in_ready   (tx_in_ready),
        .out_data   (tx_out_data),
        .out_valid  (tx_out_valid),
        .out_ready  (tx_pop),
        .fill_count (tx_count)
    );

    assign tx_pop = tx_out_valid && (!tx_word_valid || tx_word_ready);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_word       <= '0;
            tx_word_valid <= 1'b0;
        end else if (tx_pop) begin
            tx_word       <= tx_out_data;
            tx_word_valid <= 1'b1;
        end else if (tx_word_ready) begin
            tx_word_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_byte <= STATUS_RST;
        end else begin
            status_byte[ST_EMPTY]             <= !rx_out_valid;
            status_byte[ST_LEVEL]             <= rx_count >= (FIFO_PTR_W+1)'(FIFO_LEVEL);
            status_byte[ST_FULL]              <= !rx_in_ready;
            status_byte[ST_PARITY]            <= parity_fault_flag;
            status_byte[ST_TX_LSB+ST_EMPTY]   <= !tx_out_valid;
            status_byte[ST_TX_LSB+ST_LEVEL]   <= tx_count >= (FIFO_PTR_W+1)'(FIFO_LEVEL);
            status_byte[ST_TX_LSB+ST_FULL]    <= !tx_in_ready;
            status_byte[7]                    <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_clock_mhz <= 8'h0;
            rx_slow_rate     <= 1'b0;
            rx_parity_even   <= 1'b0;
            tx_slow_rate     <= 1'b0;
            tx_parity_even   <= 1'b0;
            loopback_en      <= 1'b0;
        end else begin
            sample_clock_mhz <= clock_mhz(INPUT_CLOCK_CODE);
            rx_slow_rate     <= rx_ctrl[RXC_RATE];
            rx_parity_even   <= rx_ctrl[RXC_PARITY];
            tx_slow_rate     <= tx_ctrl[TXC_RATE];
            tx_parity_even   <= tx_ctrl[TXC_PARITY];
            loopback_en      <= tx_ctrl[TXC_LOOP];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    set_wins_a: assert property (take && parity_bad && clear_pe |=> parity_fault_flag)
        else $error("parity fault lost against a clear");
    fault_sticky_a: assert property (parity_fault_flag && !clear_pe |=> parity_fault_flag)
        else $error("parity fault dropped without a clear");
    fault_clear_a: assert property (clear_pe && !(take && parity_bad) |=> !parity_fault_flag ##1 !status_byte[ST_PARITY])
        else $error("parity fault not cleared");
    label_filter_a: assert property (accept && rx_ctrl[RXC_LABEL_EN] |-> label_hit)
        else $error("unmatched label stored");
    sdi_filter_a: assert property (accept && rx_ctrl[RXC_SDI_EN] |-> stage_data[WORD_SDI_HI:WORD_SDI_LO] == rx_ctrl[RXC_SDI_HI:RXC_SDI_LO])
        else $error("word with wrong SDI stored");
    reload_ptr_a: assert property (rx_ctrl[RXC_RELOAD] |=> label_wr_ptr == '0)
        else $error("label pointer not zeroed by reload");
    empty_read_a: assert property (rx_pop && !rx_out_valid |=> read_data == 32'h0)
        else $error("empty read did not return zero");
    empty_status_a: assert property (!rx_out_valid [*2] |=> status_byte[ST_EMPTY])
        else $error("receive empty flag wrong");
    level_status_a: assert property (status_byte[ST_LEVEL] == ($past(rx_count) >= (FIFO_PTR_W+1)'(FIFO_LEVEL)))
        else $error("receive level flag wrong");
    reserved_zero_a: assert property (!tx_ctrl[TXC_RSVD])
        else $error("reserved transmit bit set");

    rx_store_c: cover property (accept ##1 rx_pop);
    fault_set_c: cover property (take && parity_bad ##[1:20] clear_pe);
    tx_send_c: cover property (wr_here && target_register_code == SEL_TX_DATA ##[1:10] tx_word_valid && tx_word_ready);
    rx_full_c: cover property (status_byte[ST_FULL]);

endmodule : serial_avionics_channel_regs

// ===== serial_avionics_channel_regs_tb.sv
// Self-checking bench for the channel register bank, label filter and word FIFOs.
// Assumes serial_engine_model on the word ports and a small FIFO depth of 8 with level 3.
`timescale 1ns/1ps
`define CHECK(got, want) begin compares++; if ((got) !== (want)) begin miscompares++; \
    $display("MISMATCH %0t: got %0h, expected %0h", $time, (got), (want)); end end

module serial_avionics_channel_regs_tb import avionics_chan_pkg::*; ;
    localparam int         DEPTH = 8;
    localparam int         LEVEL = 3;
    localparam logic [3:0] CH    = CHANNEL_DEFAULT;
    logic        ref_clk = 1'b0;
    logic        sys_rst, register_write_strobe, read_request, tx_hold, tx_slow, rd_pend;
    logic [1:0]  target_register_code;
    logic [3:0]  write_channel, read_channel;
    logic [31:0] write_data, read_data, rx_word, tx_word, seed, e, ce;
    logic [7:0]  status_byte, sample_clock_mhz;
    logic        rx_word_valid, rx_word_ready, tx_word_valid, tx_word_ready;
    logic        rx_slow_rate, rx_parity_even, tx_slow_rate, tx_parity_even, loopback_en;
    logic [31:0] held[$], exp_q[$], tx_exp[$];
    int          compares, miscompares;

    serial_avionics_channel_regs #(.FIFO_DEPTH(DEPTH), .FIFO_LEVEL(LEVEL), .FIFO_PTR_W(3), .LABEL_SIZE(4))
    serial_avionics_channel_regs_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .register_write_strobe(register_write_strobe),
        .target_register_code(target_register_code), .write_channel(write_channel),
        .write_data(write_data), .read_request(read_request), .read_channel(read_channel),
        .read_data(read_data), .status_byte(status_byte), .rx_word(rx_word),
        .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready), .tx_word(tx_word),
        .tx_word_valid(tx_word_valid), .tx_word_ready(tx_word_ready),
        .sample_clock_mhz(sample_clock_mhz), .rx_slow_rate(rx_slow_rate),
        .rx_parity_even(rx_parity_even), .tx_slow_rate(tx_slow_rate),
        .tx_parity_even(tx_parity_even), .loopback_en(loopback_en));

    serial_engine_model serial_engine_model_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .rx_word_ready(rx_word_ready), .tx_word_ready(tx_word_ready), .tx_hold(tx_hold),
        .tx_slow(tx_slow));

    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Random payload with the given label and SDI field, made good under odd parity.
    function automatic logic [31:0] word(input logic [7:0] label, input logic [1:0] sdi);
        logic [31:0] w;
        w = rnd();
        w[7:0] = label;
        w[9:8] = sdi;
        w[31] = 1'b0;
        w[31] = ~(^w);
        return w;
    endfunction : word

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : settle

    task automatic wr(input logic [1:0] code, input logic [3:0] ch, input logic [31:0] data);
        @(posedge ref_clk);
        register_write_strobe <= 1'b1;
        target_register_code  <= code;
        write_channel         <= ch;
        write_data            <= data;
        @(posedge ref_clk);
        register_write_strobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] ch);
        @(posedge ref_clk);
        read_request <= 1'b1;
        read_channel <= ch;
        if (ch == CH) begin
            exp_q.push_back(held.size() > 0 ? held.pop_front() : 32'h0);
        end
        @(posedge ref_clk);
        read_request <= 1'b0;
    endtask : rd

    task automatic push_rx(input logic [31:0] w, input bit keep);
        serial_engine_model_inst.send(w);
        if (keep) begin
            held.push_back(w);
        end
    endtask : push_rx

    task automatic drain();
        for (int i = 0; i < 300 && serial_engine_model_inst.pending() > 0; i++) @(posedge ref_clk);
        settle(8);
    endtask : drain

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    // Checks each read one cycle after it was taken and each word the engine takes.
    always @(posedge ref_clk) begin
        if (rd_pend) begin
            ce = exp_q.pop_front();
            `CHECK(read_data, ce)
        end
        rd_pend = read_request && read_channel == CH && !sys_rst;
        if (tx_word_valid && tx_word_ready && !sys_rst) begin
            if (tx_exp.size() == 0) begin
                `CHECK(1'b0, 1'b1)
            end else begin
                ce = tx_exp.pop_front();
                `CHECK(tx_word, ce)
            end
        end
    end

    initial begin
        #(25ns * 20000);
        miscompares++;
        print_verdict();
    end

    initial begin
        seed = 32'hafce93a9;
        sys_rst = 1'b1;
        register_write_strobe = 1'b0;
        target_register_code = 2'h0;
        write_channel = 4'h0;
        write_data = 32'h0;
        read_request = 1'b0;
        read_channel = 4'h0;
        tx_hold = 1'b0;
        tx_slow = 1'b0;
        rd_pend = 1'b0;
        settle(3);
        `CHECK(status_byte, STATUS_RST)
        sys_rst <= 1'b0;
        settle(2);
        `CHECK(sample_clock_mhz, 8'h30)
        `CHECK({status_byte[6:0], rx_slow_rate, rx_parity_even}, 9'h044)
        // Label filter, then SDI match on top of it.
        wr(SEL_RX_CTRL, CH, 32'h80);
        wr(SEL_RX_CTRL, CH, 32'h02);
        wr(SEL_LABEL, CH, 32'h78);
        push_rx(word(8'h78, 2'b00), 1);
        push_rx(word(8'h11, 2'b00), 0);
        drain();
        wr(SEL_RX_CTRL, CH, 32'h52);
        push_rx(word(8'h78, 2'b10), 1);
        push_rx(word(8'h78, 2'b01), 0);
        drain();
        rd(CH);
        rd(CH);
        // Reload forgets every stored label.
        wr(SEL_RX_CTRL, CH, 32'h80);
        wr(SEL_RX_CTRL, CH, 32'h02);
        push_rx(word(8'h78, 2'b00), 0);
        drain();
        rd(CH);
        settle(4);
        `CHECK(status_byte[0], 1'b1)
        // Sticky parity fault and its one-shot clear.
        wr(SEL_RX_CTRL, CH, 32'h00);
        push_rx(word(8'h20, 2'b00) ^ 32'h1, 1);
        drain();
        `CHECK(status_byte[3], 1'b1)
        push_rx(word(8'h21, 2'b00), 1);
        drain();
        `CHECK(status_byte[3], 1'b1)
        wr(SEL_RX_CTRL, CH, 32'h04);
        push_rx(word(8'h22, 2'b00), 1);
        drain();
        `CHECK(status_byte[3], 1'b0)
        repeat (3) rd(CH);
        // Fill the receive FIFO, then walk the level boundary while draining.
        for (int i = 0; i < DEPTH; i++) begin
            e = rnd();
            push_rx(word(e[7:0], e[9:8]), 1);
        end
        drain();
        `CHECK(status_byte[2:0], 3'b110)
        rd(4'h3);
        repeat (DEPTH - LEVEL) rd(CH);
        settle(4);
        `CHECK(status_byte[2:0], 3'b010)
        rd(CH);
        settle(4);
        `CHECK(status_byte[1], 1'b0)
        repeat (LEVEL) rd(CH);
        settle(4);
        `CHECK(status_byte[0], 1'b1)
        // Configuration outputs; a write to another channel is ignored.
        wr(SEL_TX_CTRL, CH, 32'h0f);
        wr(SEL_TX_CTRL, 4'h3, 32'h00);
        wr(SEL_RX_CTRL, CH, 32'h09);
        settle(3);
        `CHECK({tx_slow_rate, tx_parity_even, loopback_en, rx_slow_rate, rx_parity_even}, 5'h1f)
        // Transmit path: the stalled engine lets the FIFO fill and refuse one word.
        tx_hold <= 1'b1;
        for (int i = 0; i < DEPTH + 2; i++) begin
            e = rnd();
            wr(SEL_TX_DATA, CH, e);
            if (i <= DEPTH) begin
                tx_exp.push_back(e);
            end
        end
        settle(4);
        `CHECK(status_byte[6:4], 3'b110)
        tx_slow <= 1'b1;
        tx_hold <= 1'b0;
        for (int i = 0; i < 400 && tx_exp.size() > 0; i++) @(posedge ref_clk);
        settle(6);
        `CHECK(status_byte[6:4], 3'b001)
        `CHECK(tx_exp.size() == 0, 1'b1)
        print_verdict();
    end
endmodule : serial_avionics_channel_regs_tb

// ===== serial_engine_model.sv
// Behavioural serial engine that faces the channel's receive and transmit word ports.
// Assumes the bench queues receive words through send and steers transmit stalling.
`timescale 1ns/1ps

module serial_engine_model (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Receive words towards the channel
    output logic      [31:0] rx_word,
    output logic             rx_word_valid,
    input  wire logic        rx_word_ready,
    // Transmit words from the channel
    output logic             tx_word_ready,
    // Bench control
    input  wire logic        tx_hold,
    input  wire logic        tx_slow
);
    logic [31:0] send_q[$];

    task automatic send(input logic [31:0] w);
        send_q.push_back(w);
    endtask : send

    function automatic int pending();
        return send_q.size() + int'(rx_word_valid);
    endfunction : pending

    // A word stays up until ready is seen; idle data keeps changing so it is never mistaken for a word.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_word_valid <= 1'b0;
            rx_word       <= 32'h0;
        end else if (!rx_word_valid || rx_word_ready) begin
            if (send_q.size() > 0) begin
                rx_word       <= send_q.pop_front();
                rx_word_valid <= 1'b1;
            end else begin
                rx_word_valid <= 1'b0;
                rx_word       <= ~rx_word;
            end
        end
    end

    // A slow engine takes a word only every other cycle.
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_word_ready <= 1'b0;
        end else begin
            tx_word_ready <= !tx_hold && (!tx_slow || !tx_word_ready);
        end
    end
endmodule : serial_engine_model
